// File: logic/rrt_regs.vh
/*
 * register map, presets and step timing of the receive response timers.
 * assumes the includer applies these to an 8-bit address and data port.
 */
`ifndef RRT_REGS_VH
`define RRT_REGS_VH

// register offsets
`define RRT_ADDR_REPLY_WAIT 8'h07
`define RRT_ADDR_BLANKING 8'h08
`define RRT_ADDR_STATUS 8'h10
`define RRT_ADDR_MASK 8'h11
`define RRT_ADDR_STATE 8'h12
`define RRT_ADDR_REMAIN 8'h13

// reset values
`define RRT_REPLY_WAIT_RST 8'h0e
`define RRT_BLANKING_RST 8'h1f
`define RRT_MASK_RST 8'h01
`define RRT_STATUS_RST 8'h00

// status register bit positions
`define RRT_ST_NO_REPLY 0
`define RRT_ST_BLANK_END 1
`define RRT_ST_REPLY 2
`define RRT_ST_NBITS 3

// protocol select field: bit 1 set means high data rate
`define RRT_PROTO_RATE_BIT 1
`define RRT_PROTO_RST 5'h02

// step sizes in ns and in carrier cycles
`define RRT_NR_STEP_NS 37760
`define RRT_BL_STEP_NS 9440
`define RRT_NR_STEP_CARRIER 512
`define RRT_BL_STEP_CARRIER 128

// preset windows in us, rounded to whole steps
`define RRT_NR_HI_US 755
`define RRT_NR_LO_US 1812
`define RRT_BL_VICC_US 293
`define RRT_STEPS(us, step) (((us) * 1000 + (step) / 2) / (step))

`endif

// File: logic/rrt_prescaler.v
/*
 * carrier prescaler: one tick every DIV sampled carrier edges.
 * assumes edge_in is a one-cycle pulse on sys_clk_in.
 */
`timescale 1ns/1ps

module rrt_prescaler #(
	parameter [9:0] DIV = 10'h200
) (
	input wire sys_clk_in,
	input wire rst_in,
	input wire clr_in,
	input wire edge_in,
	output reg tick_out
);

localparam [9:0] LAST = DIV - 10'h001;

reg [9:0] cnt_ff;

// clear restarts a step so the first step is full length
always @(posedge sys_clk_in) begin
	if (rst_in || clr_in) begin
		cnt_ff <= 10'h000;
		tick_out <= 1'b0;
	end else if (edge_in) begin
		if (cnt_ff == LAST) begin
			cnt_ff <= 10'h000;
			tick_out <= 1'b1; // RULE11
		end else begin
			cnt_ff <= cnt_ff + 10'h001;
			tick_out <= 1'b0;
		end
	end else begin
		tick_out <= 1'b0;
	end
end

endmodule

// File: logic/rrt_timers.v
/*
 * no-reply timer and receive blanking timer with their registers.
 * assumes a same-clock transmitter, decoder and protocol register;
 * the carrier and the chip enable arrive as asynchronous pins.
 */
// Our own choice: the address-and-strobe port.
// Overview of operation
// (RULE1) no-reply timer runs from transmit end-of-frame until a reply starts
// (RULE2) window expiry without reply raises interrupt and sets no-reply flag
// (RULE3) no-reply window is register value times one step, values 1 to 255
// (RULE4) wait register defaults on reset, chip disabled, protocol write
// (RULE5) protocol write presets 755 us high rate, 1812 us low rate
// (RULE6) during blanking the decoders stay in reset and receive is ignored
// (RULE7) blanking time is register value times one step, values 1 to 255
// (RULE8) protocol write presets blanking to minimum tag reply time
// (RULE9) vicinity-card blanking preset is about 293 us
// (RULE10) protocol field picks high or low rate; default is high rate
// (RULE11) steps are 512 and 128 carrier cycles via synchronous prescalers
`timescale 1ns/1ps
`include "rrt_regs.vh"

module rrt_timers (
	input wire sys_clk_in,
	input wire rst_in,
	input wire chip_en_in,
	input wire carrier_in,
	input wire [7:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	output reg [7:0] reg_rdata_out,
	input wire proto_wr_in,
	input wire [4:0] proto_sel_in,
	input wire tx_eof_in,
	input wire rx_start_in,
	output reg decoder_reset_out,
	output reg rx_start_out,
	output reg no_reply_out,
	output reg irq_out
);

//////////////////////////////////////////////////////////////////////
// constants

localparam integer NR_HI_I =
	`RRT_STEPS(`RRT_NR_HI_US, `RRT_NR_STEP_NS);
localparam integer NR_LO_I =
	`RRT_STEPS(`RRT_NR_LO_US, `RRT_NR_STEP_NS);
localparam integer BL_I =
	`RRT_STEPS(`RRT_BL_VICC_US, `RRT_BL_STEP_NS);
localparam [7:0] NR_HI = NR_HI_I[7:0];
localparam [7:0] NR_LO = NR_LO_I[7:0];
localparam [7:0] BL_VICC = BL_I[7:0];
localparam integer NR_DIV_I = `RRT_NR_STEP_CARRIER;
localparam integer BL_DIV_I = `RRT_BL_STEP_CARRIER;
localparam [9:0] NR_DIV = NR_DIV_I[9:0];
localparam [9:0] BL_DIV = BL_DIV_I[9:0];

// receive path states
localparam [1:0] RX_IDLE = 2'b00;
localparam [1:0] RX_BLANK = 2'b01;
localparam [1:0] RX_LISTEN = 2'b10;

//////////////////////////////////////////////////////////////////////
// functions

// true on the tick that completes the last step; zero never expires
function step_hit;
	input [7:0] cnt;
	input [7:0] lim;
	begin
		step_hit = (lim != 8'h00) && ((cnt + 8'h01) == lim);
	end
endfunction

// register address match
function addr_is;
	input [7:0] addr;
	input [7:0] want;
	begin
		addr_is = (addr == want);
	end
endfunction

//////////////////////////////////////////////////////////////////////
// pin synchronisers

reg ce_meta_ff;
reg ce_ff;
reg car_meta_ff;
reg car_sync_ff;
reg car_prev_ff;
wire car_edge;

// first stage feeds only the second; edge detect uses later stages
always @(posedge sys_clk_in) begin
	if (rst_in) begin
		ce_meta_ff <= 1'b0;
		ce_ff <= 1'b0;
		car_meta_ff <= 1'b0;
		car_sync_ff <= 1'b0;
		car_prev_ff <= 1'b0;
	end else begin
		ce_meta_ff <= chip_en_in;
		ce_ff <= ce_meta_ff;
		car_meta_ff <= carrier_in;
		car_sync_ff <= car_meta_ff;
		car_prev_ff <= car_sync_ff;
	end
end

// carrier must stay below half the system clock to be counted
assign car_edge = car_sync_ff & ~car_prev_ff;

//////////////////////////////////////////////////////////////////////
// preset source

wire preset_now;
wire rate_high;
wire [7:0] nr_preset;

// chip disable holds presets, protocol write reloads them
assign preset_now = ~ce_ff | proto_wr_in; // RULE4
assign rate_high = proto_sel_in[`RRT_PROTO_RATE_BIT]; // RULE10
assign nr_preset = rate_high ? NR_HI : NR_LO; // RULE5

//////////////////////////////////////////////////////////////////////
// register writes

reg [7:0] reply_wait_ff;
reg [7:0] blanking_ff;
reg [7:0] mask_ff;
wire wr_wait;
wire wr_blank;
wire wr_mask;

assign wr_wait = reg_wr_in && addr_is(reg_addr_in, `RRT_ADDR_REPLY_WAIT);
assign wr_blank = reg_wr_in && addr_is(reg_addr_in, `RRT_ADDR_BLANKING);
assign wr_mask = reg_wr_in && addr_is(reg_addr_in, `RRT_ADDR_MASK);

// preset beats a software write landing in the same cycle
always @(posedge sys_clk_in) begin
	if (rst_in) begin
		reply_wait_ff <= `RRT_REPLY_WAIT_RST; // RULE4
		blanking_ff <= `RRT_BLANKING_RST;
	end else if (~ce_ff) begin
		reply_wait_ff <= `RRT_REPLY_WAIT_RST; // RULE4
		blanking_ff <= `RRT_BLANKING_RST;
	end else if (proto_wr_in) begin
		reply_wait_ff <= nr_preset; // RULE5
		blanking_ff <= BL_VICC; // RULE8 RULE9
	end else begin
		if (wr_wait) begin
			reply_wait_ff <= reg_wdata_in; // RULE3
		end
		if (wr_blank) begin
			blanking_ff <= reg_wdata_in; // RULE7
		end
	end
end

always @(posedge sys_clk_in) begin
	if (rst_in) begin
		mask_ff <= `RRT_MASK_RST;
	end else if (wr_mask) begin
		mask_ff <= reg_wdata_in;
	end
end

//////////////////////////////////////////////////////////////////////
// prescalers

wire nr_tick;
wire bl_tick;
wire start_tx;

// a new frame end restarts both timers from zero
assign start_tx = tx_eof_in & ce_ff;

rrt_prescaler #(
	.DIV(NR_DIV)
) u_nr_pre (
	.sys_clk_in(sys_clk_in),
	.rst_in(rst_in),
	.clr_in(start_tx | preset_now),
	.edge_in(car_edge),
	.tick_out(nr_tick)
);

rrt_prescaler #(
	.DIV(BL_DIV)
) u_bl_pre (
	.sys_clk_in(sys_clk_in),
	.rst_in(rst_in),
	.clr_in(start_tx | preset_now),
	.edge_in(car_edge),
	.tick_out(bl_tick)
);

//////////////////////////////////////////////////////////////////////
// receive path: blanking then listening

reg [1:0] rx_state_ff;
reg [1:0] nxt_rx_state;
reg [7:0] bl_cnt_ff;
reg [7:0] nxt_bl_cnt;
reg blank_end;
reg reply_seen;

always @* begin
	nxt_rx_state = rx_state_ff;
	nxt_bl_cnt = bl_cnt_ff;
	blank_end = 1'b0;
	reply_seen = 1'b0;
	case (rx_state_ff)
	RX_IDLE: begin
		if (start_tx) begin
			nxt_rx_state = RX_BLANK;
			nxt_bl_cnt = 8'h00;
		end
	end
	RX_BLANK: begin
		// receive input is dropped here
		if (start_tx) begin
			nxt_bl_cnt = 8'h00;
		end else if (blanking_ff == 8'h00) begin
			nxt_rx_state = RX_LISTEN;
			blank_end = 1'b1;
		end else if (bl_tick) begin
			if (step_hit(bl_cnt_ff, blanking_ff)) begin // RULE7
				nxt_rx_state = RX_LISTEN;
				blank_end = 1'b1;
			end else begin
				nxt_bl_cnt = bl_cnt_ff + 8'h01;
			end
		end
	end
	RX_LISTEN: begin
		if (start_tx) begin
			nxt_rx_state = RX_BLANK;
			nxt_bl_cnt = 8'h00;
		end else if (rx_start_in) begin
			reply_seen = 1'b1;
		end
	end
	default: begin
		nxt_rx_state = RX_IDLE;
	end
	endcase
	if (preset_now) begin
		nxt_rx_state = RX_IDLE;
		nxt_bl_cnt = 8'h00;
		blank_end = 1'b0;
		reply_seen = 1'b0;
	end
end

always @(posedge sys_clk_in) begin
	if (rst_in) begin
		rx_state_ff <= RX_IDLE;
		bl_cnt_ff <= 8'h00;
	end else begin
		rx_state_ff <= nxt_rx_state;
		bl_cnt_ff <= nxt_bl_cnt;
	end
end

// decoders held in reset while blanking, replies only passed after
always @(posedge sys_clk_in) begin
	if (rst_in) begin
		decoder_reset_out <= 1'b1;
		rx_start_out <= 1'b0;
	end else begin
		decoder_reset_out <= (nxt_rx_state != RX_LISTEN); // RULE6
		rx_start_out <= reply_seen; // RULE6
	end
end

//////////////////////////////////////////////////////////////////////
// no-reply timer

reg nr_run_ff;
reg [7:0] nr_cnt_ff;
reg nr_expire;

// expiry and reply in one cycle: the reply wins, the slot is not empty
always @* begin
	nr_expire = nr_run_ff & ~reply_seen & ~start_tx & nr_tick &
		step_hit(nr_cnt_ff, reply_wait_ff); // RULE3
end

always @(posedge sys_clk_in) begin
	if (rst_in) begin
		nr_run_ff <= 1'b0;
		nr_cnt_ff <= 8'h00;
	end else if (preset_now) begin
		nr_run_ff <= 1'b0;
		nr_cnt_ff <= 8'h00;
	end else if (start_tx) begin
		nr_run_ff <= 1'b1; // RULE1
		nr_cnt_ff <= 8'h00;
	end else if (reply_seen || nr_expire) begin
		nr_run_ff <= 1'b0; // RULE1
	end else if (nr_run_ff && nr_tick) begin
		nr_cnt_ff <= nr_cnt_ff + 8'h01;
	end
end

// one-cycle flag to the shared status register
always @(posedge sys_clk_in) begin
	if (rst_in) begin
		no_reply_out <= 1'b0;
	end else begin
		no_reply_out <= nr_expire; // RULE2
	end
end

//////////////////////////////////////////////////////////////////////
// status, mask and interrupt

reg [7:0] status_ff;
wire [`RRT_ST_NBITS-1:0] ev_set;
wire rd_status;
wire [7:0] nxt_status;

assign ev_set[`RRT_ST_NO_REPLY] = nr_expire; // RULE2
assign ev_set[`RRT_ST_BLANK_END] = blank_end;
assign ev_set[`RRT_ST_REPLY] = reply_seen;
assign rd_status = reg_rd_in && addr_is(reg_addr_in, `RRT_ADDR_STATUS);

// read clears, but an event in the read cycle still sets its bit
genvar gi;
generate
	for (gi = 0; gi < `RRT_ST_NBITS; gi = gi + 1) begin : g_st
		assign nxt_status[gi] = ev_set[gi] |
			(status_ff[gi] & ~rd_status);
	end
endgenerate
assign nxt_status[7:`RRT_ST_NBITS] = {(8 - `RRT_ST_NBITS){1'b0}};

always @(posedge sys_clk_in) begin
	if (rst_in) begin
		status_ff <= `RRT_STATUS_RST;
		irq_out <= 1'b0;
	end else begin
		status_ff <= nxt_status;
		irq_out <= |(nxt_status & mask_ff); // RULE2
	end
end

//////////////////////////////////////////////////////////////////////
// register reads

reg [7:0] rd_mux;

// unmapped addresses read as zero
always @* begin
	case (reg_addr_in)
	`RRT_ADDR_REPLY_WAIT: rd_mux = reply_wait_ff;
	`RRT_ADDR_BLANKING: rd_mux = blanking_ff;
	`RRT_ADDR_STATUS: rd_mux = status_ff;
	`RRT_ADDR_MASK: rd_mux = mask_ff;
	`RRT_ADDR_STATE: rd_mux = {4'h0, ce_ff, nr_run_ff, rx_state_ff};
	`RRT_ADDR_REMAIN: rd_mux = nr_cnt_ff;
	default: rd_mux = 8'h00;
	endcase
end

// data valid only in the cycle after the read strobe
always @(posedge sys_clk_in) begin
	if (rst_in) begin
		reg_rdata_out <= 8'h00;
	end else if (reg_rd_in) begin
		reg_rdata_out <= rd_mux;
	end else begin
		reg_rdata_out <= 8'h00;
	end
end

endmodule

// File: test/rrt_checker.sv
/* checker for rrt_timers port relations.
   assumes it is bound to rrt_timers and sees only its ports. */
`timescale 1ns/1ps
module rrt_checker (
	input wire sys_clk_in,
	input wire rst_in,
	input wire [7:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [7:0] reg_rdata_out,
	input wire proto_wr_in,
	input wire tx_eof_in,
	input wire rx_start_in,
	input wire decoder_reset_out,
	input wire rx_start_out,
	input wire no_reply_out,
	input wire irq_out
);
	reg [7:0] mask_ff;
	reg replied_ff;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	////////////////////////////////////////////////////////////////////
	// shadow of the mask and of a reply seen since the last frame end
	always @(posedge sys_clk_in) begin
		if (rst_in)
			mask_ff <= 8'h01;
		else if (reg_wr_in && reg_addr_in == 8'h11)
			mask_ff <= reg_wdata_in;
		if (rst_in || tx_eof_in || proto_wr_in)
			replied_ff <= 1'b0;
		else if (rx_start_out)
			replied_ff <= 1'b1;
	end
	////////////////////////////////////////////////////////////////////
	a_read_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
		else $error("read data outside the read answer cycle");
	a_reply_cause: assert property (rx_start_out |-> $past(rx_start_in))
		else $error("reply start without a receiver start");
	a_no_reply_pulse: assert property (no_reply_out |=> !no_reply_out)
		else $error("no-reply flag longer than one cycle");
	a_eof_blanks: assert property (tx_eof_in || proto_wr_in |=> decoder_reset_out)
		else $error("decoders not held after frame end");
	a_eof_quiet: assert property (tx_eof_in |-> ##3 !no_reply_out [*8])
		else $error("no-reply right after frame end");
	a_stop_reply: assert property (replied_ff |-> !no_reply_out)
		else $error("no-reply after a reply started");
	a_irq_no_reply: assert property (no_reply_out && mask_ff[0] |-> irq_out)
		else $error("no interrupt on unmasked no-reply");
	a_irq_clear: assert property (reg_rd_in && reg_addr_in == 8'h10 &&
		mask_ff == 8'h01 |=> irq_out == no_reply_out)
		else $error("interrupt not cleared by status read");
endmodule
bind rrt_timers rrt_checker i_chk (.sys_clk_in, .rst_in, .reg_addr_in,
	.reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .proto_wr_in,
	.tx_eof_in, .rx_start_in, .decoder_reset_out, .rx_start_out,
	.no_reply_out, .irq_out);

// File: test/rrt_carrier_src.sv
/* far-side carrier oscillator model.
   assumes a carrier period above two system clocks. */
`timescale 1ns/1ps
module rrt_carrier_src #(
	parameter int HALF_NS = 20
) (
	output logic carrier_out
);
	// runs free: the carrier is the reader's own oscillator, not framed
	// offset by 1 ns so carrier edges never meet a system clock edge
	initial begin
		carrier_out = 1'b0;
		#1;
		forever #(HALF_NS) carrier_out = ~carrier_out;
	end
endmodule

// File: test/rrt_timers_bench.sv
/* self-checking bench for rrt_timers: registers, presets, frames.
   assumes rrt_carrier_src drives the carrier and rrt_checker is bound. */
`timescale 1ns/1ps
module rrt_timers_bench;
	localparam int CP = 5; // carrier period in system clocks
	logic sys_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic chip_en_in = 1'b0;
	logic carrier_in;
	logic [7:0] reg_addr_in = 8'h00;
	logic [7:0] reg_wdata_in = 8'h00;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic proto_wr_in = 1'b0;
	logic [4:0] proto_sel_in = 5'h02;
	logic tx_eof_in = 1'b0;
	logic rx_start_in = 1'b0;
	logic [7:0] reg_rdata_out;
	logic decoder_reset_out, rx_start_out, no_reply_out, irq_out;
	logic [7:0] ra [4] = '{8'h07, 8'h08, 8'h11, 8'h20};
	logic [7:0] rv [4] = '{8'h0e, 8'h1f, 8'h01, 8'h00};
	logic [7:0] d;
	int checks = 0;
	int bad_count = 0;
	int cyc = 0;
	int t0;
	always #4 sys_clk_in = ~sys_clk_in;
	always @(posedge sys_clk_in) cyc <= cyc + 1;
	rrt_carrier_src #(.HALF_NS(20)) i_car (.carrier_out(carrier_in));
	rrt_timers i_dut (.sys_clk_in, .rst_in, .chip_en_in, .carrier_in,
		.reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
		.proto_wr_in, .proto_sel_in, .tx_eof_in, .rx_start_in,
		.decoder_reset_out, .rx_start_out, .no_reply_out, .irq_out);
	////////////////////////////////////////////////////////////////////
	function automatic int steps(input int us, input int ns);
		return (us * 1000 + ns / 2) / ns;
	endfunction
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			$display("mismatch %s exp %h got %h", n, e, g);
			bad_count++;
		end
	endtask
	task automatic near(input string n, input int e, input int g);
		checks++;
		if (g < e - 2 * CP || g > e + 2 * CP) begin
			$display("mismatch %s exp %0d got %0d", n, e, g);
			bad_count++;
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= v;
		reg_wr_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_rd_in <= 1'b0;
		#1 v = reg_rdata_out;
	endtask
	// s 0 pulses the frame end, s 1 a receiver start, s 2 a protocol
	// write with p as the rate bit
	task automatic pulse(input int s, input logic p);
		@(posedge sys_clk_in);
		tx_eof_in <= (s == 0) && p;
		rx_start_in <= (s == 1) && p;
		proto_wr_in <= (s == 2);
		if (s == 2) begin
			proto_sel_in <= (5'($urandom) & 5'h1d) | {3'h0, p, 1'b0};
		end
		@(posedge sys_clk_in);
		tx_eof_in <= 1'b0;
		rx_start_in <= 1'b0;
		proto_wr_in <= 1'b0;
		#1;
	endtask
	task automatic await(input int s, input int lim);
		int n = 0;
		while ((s == 0 ? decoder_reset_out : no_reply_out) !== (s != 0)) begin
			tick(1);
			n++;
			if (n > lim) begin
				chk("wait done", 8'h01, 8'h00);
				tally_and_finish();
			end
		end
	endtask
	task automatic frame(input logic [7:0] nr, input logic [7:0] bl,
		input logic reply, input logic [7:0] mask);
		int n = 0;
		wr(8'h07, nr);
		wr(8'h08, bl);
		wr(8'h11, mask);
		pulse(0, 1'b1);
		t0 = cyc;
		pulse(1, 1'b1);
		chk("blank rx", 8'h00, {7'h0, rx_start_out});
		await(0, 20000);
		near("blank len", bl * 128 * CP, cyc - t0);
		if (reply) begin
			pulse(1, 1'b1);
			chk("reply", 8'h01, {7'h0, rx_start_out});
			repeat (nr * 512 * CP + 50) begin
				tick(1);
				if (no_reply_out !== 1'b0)
					n++;
			end
			chk("late flag", 8'h00, 8'(n));
		end else begin
			await(1, 40000);
			near("window", nr * 512 * CP, cyc - t0);
			chk("irq", {7'h0, mask[0]}, {7'h0, irq_out});
		end
		rd(8'h10, d);
		chk("status", {5'h0, reply, 1'b1, !reply}, d);
		chk("irq clear", 8'h00, {7'h0, irq_out});
		rd(8'h12, d);
		chk("state", {4'h0, 1'b1, 1'b0, 2'h2}, d);
		$display("frame done reply %0d", reply);
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		d = 8'($urandom(32'hae33));
		repeat (16) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		chip_en_in <= 1'b1;
		tick(4);
		foreach (ra[i]) begin
			rd(ra[i], d);
			chk("reset value", rv[i], d);
		end
		wr(8'h07, 8'h55);
		rd(8'h07, d);
		chk("wait rw", 8'h55, d);
		@(posedge sys_clk_in);
		chip_en_in <= 1'b0;
		repeat (4) @(posedge sys_clk_in);
		chip_en_in <= 1'b1;
		tick(4);
		rd(8'h07, d);
		chk("disable default", 8'h0e, d);
		$display("register test done");
		for (int r = 0; r < 2; r++) begin
			pulse(2, r[0]);
			rd(8'h07, d);
			chk("wait preset", 8'(steps(r ? 755 : 1812, 37760)), d);
			rd(8'h08, d);
			chk("blank preset", 8'(steps(293, 9440)), d);
		end
		$display("preset test done");
		frame(8'(1 + $urandom % 3), 8'(1 + $urandom % 3), 1'b0, 8'h01);
		frame(8'(1 + $urandom % 3), 8'(1 + $urandom % 3), 1'b1, 8'h01);
		frame(8'h01, 8'h03, 1'b0, 8'h00);
		tally_and_finish();
	end
endmodule
